//--- csb_pkg.sv
// Constants, field layout and operation codes of the core register bank.
// Assumes a single core clock domain shared with the instruction datapath.
`default_nettype none

package csb_pkg;

   // Data path and address widths
   localparam int DATA_W  = 8;
   localparam int NIB_W   = 4;
   localparam int OFS_W   = 7;
   localparam int BANK_W  = 2;
   localparam int FULL_W  = OFS_W + BANK_W;
   localparam int BIT_W   = 3;

   // Core register offsets, repeated in every bank
   localparam logic [OFS_W-1:0] OFS_INDIRECT = 7'h00;
   localparam logic [OFS_W-1:0] OFS_PCL      = 7'h02;
   localparam logic [OFS_W-1:0] OFS_STATUS   = 7'h03;
   localparam logic [OFS_W-1:0] OFS_FSR      = 7'h04;
   localparam logic [OFS_W-1:0] OFS_PROGRAM_COUNTER_UPPER_LATCH   = 7'h0A;
   localparam logic [OFS_W-1:0] OFS_INTERRUPT_CONTROL   = 7'h0B;

   // General purpose file window (first 32 locations are registers)
   localparam logic [OFS_W-1:0] GPR_FIRST    = 7'h20;
   localparam int               GPR_DEPTH    = 64;
   localparam int               GPR_IDX_W    = 6;

   // Status field positions
   localparam int ST_IRP   = 7;
   localparam int ST_RP_HI = 6;
   localparam int ST_RP_LO = 5;
   localparam int ST_TO    = 4;
   localparam int ST_PD    = 3;
   localparam int ST_Z     = 2;
   localparam int ST_DC    = 1;
   localparam int ST_C     = 0;

   // Reset values: watchdog and sleep bits high after power-up
   localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
   localparam logic [DATA_W-1:0] REG_RST    = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;
   localparam logic [DATA_W:0]   CARRY_ONE  = 9'h001;
   localparam logic [NIB_W:0]    NIB_ONE    = 5'h01;

   // Operation codes presented by the datapath
   typedef enum logic [3:0] {
      OP_ADD_REG  = 4'h0,
      OP_SUB_REG  = 4'h1,
      OP_ADD_LIT  = 4'h2,
      OP_SUB_LIT  = 4'h3,
      OP_AND      = 4'h4,
      OP_IOR      = 4'h5,
      OP_XOR      = 4'h6,
      OP_MOVE     = 4'h7,
      OP_CLEAR    = 4'h8,
      OP_MOVE_W   = 4'h9,
      OP_ROT_R    = 4'hA,
      OP_ROT_L    = 4'hB,
      OP_SWAP     = 4'hC,
      OP_BIT_CLR  = 4'hD,
      OP_BIT_SET  = 4'hE,
      OP_NONE     = 4'hF
   } csb_op_e;

endpackage

`default_nettype wire

//--- csb_alu.sv
// Combinational result and flag generator for one instruction.
// Assumes operands are stable for the cycle the instruction is taken.
`timescale 1ns/1ns
`default_nettype none

module csb_alu (
   // Instruction
   input  wire csb_pkg::csb_op_e          op,
   input  wire logic [csb_pkg::DATA_W-1:0] opA,
   input  wire logic [csb_pkg::DATA_W-1:0] opW,
   input  wire logic [csb_pkg::BIT_W-1:0]  bitSel,
   input  wire logic                       carryIn,
   // Result and flags
   output logic      [csb_pkg::DATA_W-1:0] result,
   output logic                            zeroOut,
   output logic                            nibbleOut,
   output logic                            carryOut,
   output logic                            updZero,
   output logic                            updNibble,
   output logic                            updCarry
);
   import csb_pkg::*;

   logic [DATA_W:0]       sum;
   logic [NIB_W:0]        nib;
   logic [DATA_W-1:0]     addend;
   logic                  isSub;

   always_comb begin
      isSub  = (op == OP_SUB_REG) || (op == OP_SUB_LIT);
      // Subtraction adds the two's complement, so carry means no borrow
      addend = isSub ? ~opW : opW;
      sum    = {1'b0, opA} + {1'b0, addend}
               + (isSub ? CARRY_ONE : '0);
      nib    = {1'b0, opA[NIB_W-1:0]} + {1'b0, addend[NIB_W-1:0]}
               + (isSub ? NIB_ONE : '0);
      result    = opA;
      carryOut  = carryIn;
      nibbleOut = nib[NIB_W];
      updZero   = 1'b0;
      updNibble = 1'b0;
      updCarry  = 1'b0;
      unique case (op)
         OP_ADD_REG, OP_SUB_REG, OP_ADD_LIT, OP_SUB_LIT: begin
            result    = sum[DATA_W-1:0];
            carryOut  = sum[DATA_W];
            updZero   = 1'b1;
            updNibble = 1'b1;
            updCarry  = 1'b1;
         end
         OP_AND: begin
            result  = opA & opW;
            updZero = 1'b1;
         end
         OP_IOR: begin
            result  = opA | opW;
            updZero = 1'b1;
         end
         OP_XOR: begin
            result  = opA ^ opW;
            updZero = 1'b1;
         end
         OP_MOVE: begin
            updZero = 1'b1;
         end
         OP_CLEAR: begin
            result  = READ_ZERO;
            updZero = 1'b1;
         end
         OP_MOVE_W: result = opW;
         OP_ROT_R: begin
            result   = {carryIn, opA[DATA_W-1:1]};
            carryOut = opA[0];
            updCarry = 1'b1;
         end
         OP_ROT_L: begin
            result   = {opA[DATA_W-2:0], carryIn};
            carryOut = opA[DATA_W-1];
            updCarry = 1'b1;
         end
         OP_SWAP:    result = {opA[NIB_W-1:0], opA[DATA_W-1:NIB_W]};
         OP_BIT_CLR: begin
            result         = opA;
            result[bitSel] = 1'b0;
         end
         OP_BIT_SET: begin
            result         = opA;
            result[bitSel] = 1'b1;
         end
         OP_NONE:    result = opA;
      endcase
      zeroOut = (result == READ_ZERO);
   end

endmodule // csb_alu

`default_nettype wire

//--- csb_core_regs.sv
// Core register bank: status flags, bank selection, core register mirror
// and the general purpose file, executed one instruction per cycle.
// Assumes the datapath holds W and drives one request per clock at most.
//
// Overview of operation
// - Core registers answer at same offset, every bank
// - 64 by 8 file, direct or indirect
// - Flag-updating ops ignore written Z, DC, C
// - Watchdog and sleep bits never instruction-writable
// - Indirect bank bit picks banks 2/3 or 0/1
// - Direct bank bits pick one of four banks
// - Watchdog bit: set by power-up/clear/sleep, cleared timeout
// - Sleep bit: set power-up/clear, cleared by sleep
// - Zero bit follows zero result
// - Nibble carry from bit 3 on add/sub
// - Carry from top bit on add/sub
// - Subtract via two's complement; carry is inverted borrow
// - Rotates load carry with bit shifted out
// - Core registers held as storage cells in map
// - Unimplemented locations read zero
// - Registers in low 32; file at 20h and A0h
`timescale 1ns/1ns
`default_nettype none

module csb_core_regs (
   // Clock and reset
   input  wire  logic                          mclk,
   input  wire  logic                          rstn,
   // Instruction request
   input  wire  logic                          execValid,
   input  wire  csb_pkg::csb_op_e              execOp,
   input  wire  logic [csb_pkg::OFS_W-1:0]     execAddr,
   input  wire  logic [csb_pkg::DATA_W-1:0]    execLiteral,
   input  wire  logic [csb_pkg::BIT_W-1:0]     execBitSel,
   input  wire  logic                          execToFile,
   input  wire  logic [csb_pkg::DATA_W-1:0]    wIn,
   // Instruction answer
   output logic       [csb_pkg::DATA_W-1:0]    resultData,
   output logic                                resultToW,
   output logic       [csb_pkg::FULL_W-1:0]    lastAddr,
   // Watchdog and sleep events
   input  wire  logic                          watchdogClear,
   input  wire  logic                          sleepExec,
   input  wire  logic                          watchdogTimeout,
   // Program counter side
   input  wire  logic                          pcLoad,
   input  wire  logic [csb_pkg::DATA_W-1:0]    pcLowIn,
   output logic       [csb_pkg::DATA_W-1:0]    pcLow,
   output logic                                pcLowWritten,
   output logic       [csb_pkg::DATA_W-1:0]    pcUpperLatch,
   // Core state
   output logic       [csb_pkg::DATA_W-1:0]    statusFlags,
   output logic       [csb_pkg::DATA_W-1:0]    filePointer,
   output logic       [csb_pkg::DATA_W-1:0]    interruptControl
);
   import csb_pkg::*;

   // Storage
   logic [DATA_W-1:0]     statusReg;
   logic [DATA_W-1:0]     fsrReg;
   logic [DATA_W-1:0]     pclReg;
   logic [DATA_W-1:0]     pclathReg;
   logic [DATA_W-1:0]     intconReg;
   logic [DATA_W-1:0]     gprMem [GPR_DEPTH];

   // Address resolution
   logic                  viaPointer;
   logic [FULL_W-1:0]     fullAddr;
   logic [OFS_W-1:0]      ofs;
   logic [BANK_W-1:0]     bank;
   logic                  gprHit;
   logic [GPR_IDX_W-1:0]  gprIdx;
   logic [OFS_W-1:0]      gprRel;

   // Read and execute
   logic [DATA_W-1:0]     fileData;
   logic [DATA_W-1:0]     operandA;
   logic [DATA_W-1:0]     aluResult;
   logic                  aluZero;
   logic                  aluNibble;
   logic                  aluCarry;
   logic                  updZero;
   logic                  updNibble;
   logic                  updCarry;
   logic                  isLiteral;
   logic                  producesResult;
   logic                  fileWrite;
   logic                  statusWrite;
   logic                  flagsFromResult;
   logic                  take;

   assign take = execValid;

   // Operand address: pointer path when the indirect port is named
   always_comb begin
      viaPointer = (execAddr == OFS_INDIRECT);
      if (viaPointer) begin
         fullAddr = {statusReg[ST_IRP], fsrReg};
      end else begin
         fullAddr = {statusReg[ST_RP_HI:ST_RP_LO], execAddr};
      end
      ofs  = fullAddr[OFS_W-1:0];
      bank = fullAddr[FULL_W-1:OFS_W];
   end

   // File window at 20h in bank 0, aliased at A0h in bank 1.
   // Only 64 cells exist, so upper part of each window reads zero.
   always_comb begin
      gprRel = ofs - GPR_FIRST;
      gprIdx = gprRel[GPR_IDX_W-1:0];
      gprHit = !bank[1] && (ofs >= GPR_FIRST)
               && (gprRel < OFS_W'(GPR_DEPTH));
   end

   // Read side; core offsets decode regardless of bank
   always_comb begin
      fileData = READ_ZERO;
      if (gprHit) begin
         fileData = gprMem[gprIdx];
      end else begin
         unique case (ofs)
            OFS_PCL:    fileData = pclReg;
            OFS_STATUS: fileData = statusReg;
            OFS_FSR:    fileData = fsrReg;
            OFS_PROGRAM_COUNTER_UPPER_LATCH: fileData = pclathReg;
            OFS_INTERRUPT_CONTROL: fileData = intconReg;
            // Pointer aimed at the port itself reads zero
            default:    fileData = READ_ZERO;
         endcase
      end
   end

   always_comb begin
      isLiteral = (execOp == OP_ADD_LIT) || (execOp == OP_SUB_LIT);
      operandA  = isLiteral ? execLiteral : fileData;
   end

   csb_alu alu (
      .op        (execOp),
      .opA       (operandA),
      .opW       (wIn),
      .bitSel    (execBitSel),
      .carryIn   (statusReg[ST_C]),
      .result    (aluResult),
      .zeroOut   (aluZero),
      .nibbleOut (aluNibble),
      .carryOut  (aluCarry),
      .updZero   (updZero),
      .updNibble (updNibble),
      .updCarry  (updCarry)
   );

   // Which destination takes the result
   always_comb begin
      producesResult = (execOp != OP_NONE);
      fileWrite      = take && producesResult && !isLiteral
                       && (execToFile || execOp == OP_MOVE_W
                           || execOp == OP_CLEAR
                           || execOp == OP_BIT_CLR
                           || execOp == OP_BIT_SET);
      statusWrite    = fileWrite && !gprHit && (ofs == OFS_STATUS);
      // Any flag-affecting op locks out the written low three bits
      flagsFromResult = statusWrite
                        && !(updZero || updNibble || updCarry);
   end

   // Bank select bits: written value steers the very next request
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         statusReg[ST_IRP:ST_RP_LO] <= STATUS_RST[ST_IRP:ST_RP_LO];
      end else if (statusWrite) begin
         statusReg[ST_IRP:ST_RP_LO] <= aluResult[ST_IRP:ST_RP_LO];
      end
   end

   // Watchdog bit; a timeout outranks a clear arriving with it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         statusReg[ST_TO] <= STATUS_RST[ST_TO];
      end else if (watchdogTimeout) begin
         statusReg[ST_TO] <= 1'b0;
      end else if (watchdogClear || sleepExec) begin
         statusReg[ST_TO] <= 1'b1;
      end
      // No write path from the instruction side here
   end

   // Sleep bit; instruction writes never reach it
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         statusReg[ST_PD] <= STATUS_RST[ST_PD];
      end else if (sleepExec) begin
         statusReg[ST_PD] <= 1'b0;
      end else if (watchdogClear) begin
         statusReg[ST_PD] <= 1'b1;
      end
   end

   // Arithmetic flags: operation outcome beats a plain write
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         statusReg[ST_Z:ST_C] <= STATUS_RST[ST_Z:ST_C];
      end else if (take) begin
         if (updZero) begin
            statusReg[ST_Z] <= aluZero;
         end else if (flagsFromResult) begin
            statusReg[ST_Z] <= aluResult[ST_Z];
         end
         if (updNibble) begin
            statusReg[ST_DC] <= aluNibble;
         end else if (flagsFromResult) begin
            statusReg[ST_DC] <= aluResult[ST_DC];
         end
         if (updCarry) begin
            statusReg[ST_C] <= aluCarry;
         end else if (flagsFromResult) begin
            statusReg[ST_C] <= aluResult[ST_C];
         end
      end
   end

   // Core registers are plain storage cells in the map
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         fsrReg <= REG_RST;
      end else if (fileWrite && !gprHit && ofs == OFS_FSR) begin
         fsrReg <= aluResult;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pclathReg <= REG_RST;
      end else if (fileWrite && !gprHit && ofs == OFS_PROGRAM_COUNTER_UPPER_LATCH) begin
         pclathReg <= aluResult;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         intconReg <= REG_RST;
      end else if (fileWrite && !gprHit && ofs == OFS_INTERRUPT_CONTROL) begin
         intconReg <= aluResult;
      end
   end

   // Software write wins over the sequencer's own load in one cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pclReg       <= REG_RST;
         pcLowWritten <= 1'b0;
      end else begin
         pcLowWritten <= 1'b0;
         if (fileWrite && !gprHit && ofs == OFS_PCL) begin
            pclReg       <= aluResult;
            pcLowWritten <= 1'b1;
         end else if (pcLoad) begin
            pclReg <= pcLowIn;
         end
      end
   end

   // Static file has no reset; contents are undefined at power-up
   always_ff @(posedge mclk) begin
      if (fileWrite && gprHit) begin
         gprMem[gprIdx] <= aluResult;
      end
   end

   // Answer to the datapath, one cycle after the request
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         resultData <= READ_ZERO;
         resultToW  <= 1'b0;
         lastAddr   <= '0;
      end else begin
         resultToW <= take && producesResult && !fileWrite;
         if (take) begin
            resultData <= aluResult;
            lastAddr   <= fullAddr;
         end
      end
   end

   assign pcLow            = pclReg;
   assign pcUpperLatch     = pclathReg;
   assign statusFlags      = statusReg;
   assign filePointer      = fsrReg;
   assign interruptControl = intconReg;

endmodule // csb_core_regs

`default_nettype wire

//--- csb_core_regs_assertions.sv
// Checker for the core register bank, bound to its top module.
// Assumes one clock domain and the port names of csb_core_regs.
`timescale 1ns/1ns
`default_nettype none

module csb_core_regs_assertions (
   // Clock and reset
   input wire logic                         mclk,
   input wire logic                         rstn,
   // Request
   input wire logic                         execValid,
   input wire csb_pkg::csb_op_e             execOp,
   input wire logic [csb_pkg::OFS_W-1:0]    execAddr,
   input wire logic [csb_pkg::DATA_W-1:0]   execLiteral,
   input wire logic [csb_pkg::DATA_W-1:0]   wIn,
   // Events
   input wire logic                         watchdogClear,
   input wire logic                         sleepExec,
   input wire logic                         watchdogTimeout,
   // Observed state
   input wire logic [csb_pkg::DATA_W-1:0]   resultData,
   input wire logic [csb_pkg::FULL_W-1:0]   lastAddr,
   input wire logic [csb_pkg::DATA_W-1:0]   statusFlags,
   input wire logic [csb_pkg::DATA_W-1:0]   filePointer
);
   import csb_pkg::*;
   logic [8:0] litSum, litDiff, directAddr, indirectAddr;
   logic [4:0] nibSum;
   logic [7:0] clrStatus;
   logic       nibCarry, noEvent;
   assign litSum       = {1'b0, execLiteral} + {1'b0, wIn};
   assign litDiff      = {1'b0, execLiteral} + {1'b0, ~wIn} + CARRY_ONE;
   assign nibSum       = {1'b0, execLiteral[3:0]} + {1'b0, wIn[3:0]};
   assign nibCarry     = nibSum[NIB_W];
   assign directAddr   = {statusFlags[6:5], execAddr};
   assign indirectAddr = {statusFlags[ST_IRP], filePointer};
   assign clrStatus    = {3'b000, statusFlags[4:3], 1'b1, statusFlags[1:0]};
   assign noEvent      = !watchdogClear && !sleepExec && !watchdogTimeout;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   a_reset_status:
      assert property ($rose(rstn) |-> statusFlags == STATUS_RST)
      else $error("status not at reset value");
   a_timeout_clear:
      assert property (watchdogTimeout |=> !statusFlags[ST_TO])
      else $error("timeout did not clear watchdog bit");
   a_wdclear_sets:
      assert property (watchdogClear && !sleepExec && !watchdogTimeout
         |=> statusFlags[ST_TO:ST_PD] == 2'b11)
      else $error("watchdog clear did not set bits");
   a_sleep_marks:
      assert property (sleepExec && !watchdogTimeout
         |=> statusFlags[ST_TO:ST_PD] == 2'b10)
      else $error("sleep did not mark bits");
   a_event_bits_hold:
      assert property (noEvent |=> $stable(statusFlags[ST_TO:ST_PD]))
      else $error("watchdog or sleep bit moved");
   a_add_carry:
      assert property (execValid && execOp == OP_ADD_LIT
         |=> {statusFlags[ST_C], resultData} == $past(litSum))
      else $error("add literal sum or carry wrong");
   a_sub_borrow:
      assert property (execValid && execOp == OP_SUB_LIT
         |=> {statusFlags[ST_C], resultData} == $past(litDiff))
      else $error("subtract literal or borrow wrong");
   a_add_nibble:
      assert property (execValid && execOp == OP_ADD_LIT
         |=> statusFlags[ST_DC] == $past(nibCarry))
      else $error("nibble carry wrong");
   a_zero_flag:
      assert property (execValid && execOp inside {OP_ADD_LIT, OP_SUB_LIT}
         |=> statusFlags[ST_Z] == (resultData == READ_ZERO))
      else $error("zero flag disagrees with result");
   a_direct_bank:
      assert property (execValid && execAddr != OFS_INDIRECT
         |=> lastAddr == $past(directAddr))
      else $error("direct address not banked");
   a_indirect_bank:
      assert property (execValid && execAddr == OFS_INDIRECT
         |=> lastAddr == $past(indirectAddr))
      else $error("indirect address not banked");
   a_status_guard:
      assert property (execValid && execOp == OP_CLEAR
         && execAddr == OFS_STATUS && noEvent
         |=> statusFlags == $past(clrStatus))
      else $error("clear of status gave wrong value");

   c_sub_lit: cover property (execValid && execOp == OP_SUB_LIT);
   c_timeout: cover property (watchdogTimeout);
   c_indirect: cover property (execValid && execAddr == OFS_INDIRECT);
endmodule // csb_core_regs_assertions

bind csb_core_regs csb_core_regs_assertions u_chk (.mclk(mclk),
   .rstn(rstn), .execValid(execValid), .execOp(execOp),
   .execAddr(execAddr), .execLiteral(execLiteral), .wIn(wIn),
   .watchdogClear(watchdogClear), .sleepExec(sleepExec),
   .watchdogTimeout(watchdogTimeout), .resultData(resultData),
   .lastAddr(lastAddr), .statusFlags(statusFlags),
   .filePointer(filePointer));

`default_nettype wire

//--- csb_cpu_model.sv
// Datapath partner: holds W and feeds it back to the register bank.
// Assumes the bench loads W directly only on idle cycles.
`timescale 1ns/1ns
`default_nettype none

module csb_cpu_model (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // W loading
   input  wire logic       setW,
   input  wire logic [7:0] setVal,
   input  wire logic [7:0] resultData,
   input  wire logic       resultToW,
   // W towards the bank
   output logic      [7:0] wOut
);
   logic [7:0] wReg;
   // Bypass so a back-to-back op sees the new W without a bubble
   assign wOut = resultToW ? resultData : wReg;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn)
         wReg <= 8'h00;
      else if (setW)
         wReg <= setVal;
      else if (resultToW)
         wReg <= resultData;
   end
endmodule // csb_cpu_model

`default_nettype wire

//--- core_status_bank_select_tb.sv
// Bench: directed and random instruction stream against a bench model.
// Assumes csb_cpu_model supplies W; one request per clock at most.
`timescale 1ns/1ns
`default_nettype none

module core_status_bank_select_tb;
   import csb_pkg::*;
   logic       mclk, rstn, execValid, execToFile, watchdogClear, sleepExec;
   logic       watchdogTimeout, pcLoad, setW, resultToW, pcLowWritten;
   csb_op_e    execOp;
   logic [6:0] execAddr;
   logic [2:0] execBitSel;
   logic [7:0] execLiteral, wIn, setVal, pcLowIn, resultData, pcLow;
   logic [7:0] pcUpperLatch, statusFlags, filePointer, interruptControl;
   logic [8:0] lastAddr;
   int         errors, n_tests, cyc, seed = 7829;
   int         fileM[64];
   int         st, file_pointer, program_counter_low, pcu, icr, wM, rdM, laM, rtwM, plwM;
   int         probe[9] = '{2, 3, 4, 10, 11, 0, 40, 96, 1};
   int         ptr[4] = '{165, 37, 128, 3};
   int         alu[10][3] = '{'{2, 255, 1}, '{2, 15, 1}, '{2, 0, 0},
      '{3, 0, 1}, '{3, 16, 1}, '{3, 5, 5}, '{0, 0, 1}, '{1, 0, 1},
      '{10, 0, 0}, '{11, 0, 0}};

   csb_core_regs DUT (.mclk(mclk), .rstn(rstn), .execValid(execValid),
      .execOp(execOp), .execAddr(execAddr), .execLiteral(execLiteral),
      .execBitSel(execBitSel), .execToFile(execToFile), .wIn(wIn),
      .resultData(resultData), .resultToW(resultToW), .lastAddr(lastAddr),
      .watchdogClear(watchdogClear), .sleepExec(sleepExec),
      .watchdogTimeout(watchdogTimeout), .pcLoad(pcLoad),
      .pcLowIn(pcLowIn), .pcLow(pcLow), .pcLowWritten(pcLowWritten),
      .pcUpperLatch(pcUpperLatch), .statusFlags(statusFlags),
      .filePointer(filePointer), .interruptControl(interruptControl));
   csb_cpu_model cpu (.mclk(mclk), .rstn(rstn), .setW(setW),
      .setVal(setVal), .resultData(resultData), .resultToW(resultToW),
      .wOut(wIn));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   task automatic conclude;
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         errors++;
         conclude();
      end
   end

   function automatic int rnd(int n);
      return $random(seed) & n;
   endfunction

   task automatic chk(string n, logic [8:0] s, int e);
      n_tests++;
      if (s !== 9'(e)) begin
         errors++;
         $display("[FAIL] %s expected %0h seen %0h", n, e, s);
      end
   endtask

   function automatic int rd_at(int a);
      int o = a % 128;
      if (o == 2) return program_counter_low;
      if (o == 3) return st;
      if (o == 4) return file_pointer;
      if (o == 10) return pcu;
      if (o == 11) return icr;
      if (a < 256 && o >= 32 && o < 96) return fileM[o - 32];
      return 0;
   endfunction

   task automatic wr_at(int a, int v, bit p);
      int o = a % 128;
      case (o)
         2: begin
            program_counter_low = v;
            plwM = 1;
         end
         3: st = (v & 224) | (st & (p ? 31 : 24)) | (p ? 0 : v & 7);
         4: file_pointer = v;
         10: pcu = v;
         11: icr = v;
         default: if (a < 256 && o >= 32 && o < 96) fileM[o - 32] = v;
      endcase
   endtask

   task automatic model(int op, int ad, int lit, int b, bit tf);
      int a, x, r, h, c, m;
      a = (ad == 0) ? (st / 128) * 256 + file_pointer : ((st / 32) % 4) * 128 + ad;
      x = rd_at(a);
      c = st % 2;
      m = (op < 4) ? 7 : (op < 9) ? 4 : (op == 10 || op == 11) ? 1 : 0;
      h = (op > 1 ? lit : x) % 16 + (op % 2 ? 16 - wM % 16 : wM % 16);
      case (op)
         0: r = x + wM;
         1: r = x + 256 - wM;
         2: r = lit + wM;
         3: r = lit + 256 - wM;
         4: r = x & wM;
         5: r = x | wM;
         6: r = x ^ wM;
         7: r = x;
         8: r = 0;
         9: r = wM;
         10: r = c * 128 + x / 2;
         11: r = (x * 2) % 256 + c;
         12: r = (x % 16) * 16 + x / 16;
         13: r = x & ~(1 << b);
         14: r = x | (1 << b);
         default: r = x;
      endcase
      if (op < 4) c = r / 256;
      if (op == 10) c = x % 2;
      if (op == 11) c = x / 128;
      r = r % 256;
      rdM = r;
      laM = a;
      rtwM = op == 2 || op == 3 || (!tf && (op < 8 || (op > 9 && op < 13)));
      if (rtwM) wM = r;
      else if (op < 15) wr_at(a, r, m != 0);
      st = (st & ~m) | (((r == 0) * 4 + (h / 16) * 2 + c) & m);
   endtask

   task automatic check_all;
      chk("resultData", resultData, rdM);
      chk("lastAddr", lastAddr, laM);
      chk("statusFlags", statusFlags, st);
      chk("filePointer", filePointer, file_pointer);
      chk("pcLow", pcLow, program_counter_low);
      chk("pcLowWritten", pcLowWritten, plwM);
      chk("pcUpperLatch", pcUpperLatch, pcu);
      chk("interruptControl", interruptControl, icr);
      chk("resultToW", resultToW, rtwM);
      chk("wIn", wIn, wM);
   endtask

   task automatic step(bit v, int op, int ad, int lit, int b, bit tf,
                       int ev, bit pl, bit sw);
      execValid = v;
      execOp = csb_op_e'(4'(op));
      execAddr = 7'(ad);
      execLiteral = 8'(lit);
      execBitSel = 3'(b);
      execToFile = tf;
      {watchdogTimeout, sleepExec, watchdogClear} = 3'(ev);
      pcLoad = pl;
      pcLowIn = 8'(rnd(255));
      setW = sw && !v;
      setVal = 8'(lit);
      plwM = 0;
      rtwM = 0;
      if (v) model(op, ad, lit, b, tf);
      else if (sw) wM = lit;
      if (ev % 2) st = st | 24;
      if ((ev / 2) % 2) st = (st | 16) & ~8;
      if (ev >= 4) st = st & ~16;
      if (pl && !plwM) program_counter_low = pcLowIn;
      @(posedge mclk);
      #1;
      check_all();
   endtask

   task automatic do_reset;
      rstn = 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      rstn = 1'b1;
      st = 24;
      file_pointer = 0;
      program_counter_low = 0;
      pcu = 0;
      icr = 0;
      wM = 0;
      rdM = 0;
      laM = 0;
      rtwM = 0;
      plwM = 0;
      check_all();
   endtask

   initial begin
      {execValid, execToFile, watchdogClear, sleepExec} = '0;
      {watchdogTimeout, pcLoad, setW} = '0;
      execOp = OP_NONE;
      {execAddr, execLiteral, execBitSel, setVal, pcLowIn} = '0;
      do_reset();
      for (int i = 0; i < 64; i++) begin
         step(0, 0, 0, rnd(255), 0, 0, 0, 0, 1);
         step(1, 9, 32 + i, 0, 0, 1, 0, 0, 0);
      end
      // Bank write then immediate use, no wait cycle
      for (int bk = 0; bk < 4; bk++) begin
         step(0, 0, 0, bk * 32, 0, 0, 0, 0, 1);
         step(1, 9, 3, 0, 0, 1, 0, 0, 0);
         foreach (probe[k])
            step(1, 7, probe[k], 0, 0, 0, 0, 0, 0);
      end
      for (int k = 0; k < 8; k++) begin
         step(0, 0, 0, ptr[k % 4], 0, 0, 0, 0, 1);
         step(1, 9, 4, 0, 0, 1, 0, 0, 0);
         step(1, k < 4 ? 14 : 13, 3, 0, 7, 1, 0, 0, 0);
         step(1, 7, 0, 0, 0, 0, 0, 0, 0);
      end
      step(1, 8, 3, 0, 0, 1, 0, 0, 0);
      foreach (alu[k]) begin
         step(0, 0, 0, alu[k][2], 0, 0, 0, 0, 1);
         step(1, alu[k][0], 32, alu[k][1], 0, k % 2, 0, 0, 0);
      end
      for (int e = 0; e < 8; e++)
         step(0, 0, 0, 0, 0, 0, e, 0, 0);
      step(0, 0, 0, 255, 0, 0, 0, 0, 1);
      step(1, 9, 3, 0, 0, 1, 0, 0, 0);
      for (int k = 0; k < 400; k++) begin
         int ad;
         ad = rnd(1) ? probe[rnd(7)] : rnd(127);
         step(rnd(7) != 0, rnd(15), ad, rnd(255), rnd(7), rnd(1),
              rnd(15) < 2 ? rnd(7) : 0, rnd(7) == 0, rnd(1));
      end
      do_reset();
      step(1, 3, 0, 9, 0, 0, 0, 0, 0);
      conclude();
   end
endmodule // core_status_bank_select_tb

`default_nettype wire
